//--- bench/flash_core_model.sv
// core model: rc oscillator edges and the store-program strobe
// assumes go is driven just after a clock edge
module flash_core_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request and outputs
	input wire logic go,
	output logic store_strobe,
	output logic rc_edge
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph;
	// strobe is go passed straight through; the bench decides when it comes, inside or past the arm window
	assign store_strobe = go;
	// rc edge every third cycle, slower than the core clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) ph <= 2'h0;
		else ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
	end
	assign rc_edge = (ph == 2'h2);
endmodule

//--- bench/flash_prog_properties.sv
// port checker for the flash self-program controller
// assumes it is bound onto the controller with its count parameters
module flash_prog_checker #(
	parameter int unsigned RC_DIV = 100,
	parameter int unsigned PROG_COUNT = 5
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// bus and core
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PREADY,
	input wire logic STORE_STROBE,
	// flash side
	input wire logic FLASH_ERASE,
	input wire logic FLASH_WRITE,
	input wire logic LOCK_WRITE,
	input wire logic BUF_WE,
	input wire logic [7:0] FLASH_PAGE,
	input wire logic FETCH_BLOCKED,
	input wire logic CORE_HALT
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========
	// helpers
	logic [15:0] hl;
	logic [2:0] ss;
	// halt length, and cycles since a strobe (saturates so it never wraps)
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			hl <= 16'h0000;
			ss <= 3'h7;
		end else begin
			hl <= CORE_HALT ? hl + 16'h0001 : 16'h0000;
			ss <= STORE_STROBE ? 3'h0 : ((ss == 3'h7) ? ss : ss + 3'h1);
		end
	end
	// ========
	// properties
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	property p_hp; CORE_HALT |-> FLASH_PAGE >= 8'hE0; endproperty
	a_hp: assert property (p_hp) else $error("halt on low page");
	property p_br; $rose(FETCH_BLOCKED) |-> FLASH_PAGE < 8'hE0; endproperty
	a_br: assert property (p_br) else $error("block on high page");
	property p_hl; $fell(CORE_HALT) |-> int'(hl) >= (PROG_COUNT - 1) * RC_DIV; endproperty
	a_hl: assert property (p_hl) else $error("halt too short");
	property p_ex; FLASH_ERASE |-> !FLASH_WRITE && !LOCK_WRITE && !BUF_WE; endproperty
	a_ex: assert property (p_ex) else $error("two actions at once");
	property p_cs; (FLASH_ERASE || FLASH_WRITE || LOCK_WRITE || BUF_WE) |-> ss <= 3'h3; endproperty
	a_cs: assert property (p_cs) else $error("action without strobe");
	property p_nr; CORE_HALT |=> !FLASH_ERASE && !FLASH_WRITE; endproperty
	a_nr: assert property (p_nr) else $error("restart while halted");
	property p_wp; FLASH_WRITE |=> !FLASH_WRITE; endproperty
	a_wp: assert property (p_wp) else $error("write pulse too long");
	property p_rd; (PSEL && PENABLE && !PREADY) |=> PREADY; endproperty
	a_rd: assert property (p_rd) else $error("bus answer late");
	c_ht: cover property ($rose(CORE_HALT));
	c_bk: cover property ($rose(FETCH_BLOCKED));
	c_we: cover property (BUF_WE);
endmodule
bind flash_self_program_control flash_prog_checker #(.RC_DIV(RC_DIV), .PROG_COUNT(PROG_COUNT))
	i_chk (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
	.STORE_STROBE(STORE_STROBE), .FLASH_ERASE(FLASH_ERASE), .FLASH_WRITE(FLASH_WRITE),
	.LOCK_WRITE(LOCK_WRITE), .BUF_WE(BUF_WE), .FLASH_PAGE(FLASH_PAGE),
	.FETCH_BLOCKED(FETCH_BLOCKED), .CORE_HALT(CORE_HALT));

//--- bench/tb_flash_self_program_control.sv
// bench for the flash self-program controller
// assumes short counts: two rc edges a tick, five ticks an operation
module tb_flash_self_program_control import flash_prog_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0;
	logic [7:0] pa = 0, pg, epg, p, lkd, elkd;
	logic [13:0] fa = 14'h0000;
	logic [31:0] pwd = 0, r, prd, rnd = 32'haff9_4edd;
	logic prdy, perr, ers, wr, lck, bwe, blk, halt, strobe, rce;
	logic [15:0] bd, ebd;
	logic [5:0] bw, ebw;
	int failures = 0, compares = 0, cyc = 0, hc = 0, n_op = 0, n_lk = 0, n0;
	always #5 clk = ~clk;
	flash_self_program_control #(.RC_DIV(2), .PROG_COUNT(5)) i_dut (
		.CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
		.PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .STORE_STROBE(strobe),
		.FETCH_ADDR(fa), .RC_EDGE(rce), .FLASH_ERASE(ers), .FLASH_WRITE(wr),
		.LOCK_WRITE(lck), .FLASH_PAGE(pg), .LOCK_DATA(lkd), .BUF_DATA(bd), .BUF_WORD(bw),
		.BUF_WE(bwe), .FETCH_BLOCKED(blk), .CORE_HALT(halt));
	flash_core_model i_core (.clk(clk), .rst(rst), .go(go), .store_strobe(strobe),
		.rc_edge(rce));
	// ========
	// helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task finish_test();
		if (failures == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask
	// one apb transfer; holds everything until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1 && n < 50);
		if (prdy !== 1'b1) failures++;
		r = prd;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	// control write, strobe after gap cycles, then wait until idle
	task cmd(input logic [4:0] c, input int gap);
		int n;
		apb(1'b1, CTRL_ADDR, {27'h0, c});
		repeat (gap) @(posedge clk);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do begin
			apb(1'b0, CTRL_ADDR, 32'h0000_0000);
			n++;
		end while (r[SPE_BIT] !== 1'b0 && n < 100);
		if (r[SPE_BIT] !== 1'b0) failures++;
		repeat (2) @(posedge clk);
	endtask
	// tally pulses at each edge and keep what they carried
	always @(posedge clk) begin
		cyc++;
		if (halt === 1'b1) hc++;
		if (ers === 1'b1 || wr === 1'b1 || bwe === 1'b1) n_op++;
		if (ers === 1'b1 || wr === 1'b1) epg = pg;
		if (bwe === 1'b1) {ebw, ebd} = {bw, bd};
		if (lck === 1'b1) begin
			n_lk++;
			elkd = lkd;
		end
		if (cyc > 20000) begin
			failures++;
			finish_test();
		end
	end
	// ========
	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({26'h0, perr, blk, halt, ers, wr, bwe}, 32'h0000_0000);
		for (int f = 0; f < 4; f++) begin
			apb(1'b1, CFG_ADDR, 32'(f));
			apb(1'b0, STAT_ADDR, 32'h0000_0000);
			chk(r, 32'h0000_4000 - (32'h0000_0100 << (3 - f)));
		end
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			apb(1'b1, ZPTR_ADDR, rnd & 32'h0000_fffe);
			apb(1'b1, DATA_ADDR, {16'h0000, rnd[31:16]});
			cmd(CMD_FILL, 0);
			chk({ebw, ebd}, {rnd[6:1], rnd[31:16]});
		end
		p = rnd[7:0] % 8'he0;
		apb(1'b1, ZPTR_ADDR, {16'h0000, 1'b1, p, 7'h00});
		cmd(CMD_ERASE, 0);
		chk(epg, p);
		apb(1'b0, CTRL_ADDR, 32'h0000_0000);
		chk({blk, r[BSY_BIT], hc != 0}, 3'b110);
		fa <= {3'b111, rnd[10:0]};
		repeat (2) @(posedge clk);
		chk(blk, 1'b0);
		fa <= 14'h0000;
		repeat (2) @(posedge clk);
		chk(blk, 1'b1);
		cmd(CMD_FILL, 0);
		chk(blk, 1'b0);
		cmd(CMD_WRITE, 0);
		chk(blk, 1'b1);
		cmd(CMD_RRE, 0);
		chk(blk, 1'b0);
		p = {3'b111, rnd[12:8]};
		apb(1'b1, ZPTR_ADDR, {16'h0000, 1'b0, p, 7'h00});
		hc = 0;
		cmd(CMD_WRITE, 0);
		chk({epg, blk, hc >= 24 && hc <= 40}, {p, 2'b01});
		n0 = n_op;
		cmd(5'h07, 0);
		cmd(CMD_ERASE, 6);
		chk(n_op, n0);
		apb(1'b1, DATA_ADDR, {24'h00_0000, 2'b11, rnd[5:0]});
		cmd(CMD_LOCK, 0);
		chk(n_lk, 32'h0000_0001);
		chk(n_op, n0);
		chk(elkd, {2'b11, rnd[5:0]});
		finish_test();
	end
endmodule

//--- rtl/flash_prog_pkg.sv
// package for the flash self-program controller
// assumes one 100 MHz system clock and a separate slow rc timebase input
package flash_prog_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned PROG_MIN_US = 3700;
	localparam int unsigned PROG_MAX_US = 4500;
	// rc tick period in ns (one tick per us from the rc divider)
	localparam int unsigned RC_TICK_NS = 1000;
	localparam int unsigned PROG_TICKS = (PROG_MIN_US * 1000 + RC_TICK_NS - 1) / RC_TICK_NS;
	localparam int unsigned ARM_CYCLES = 4;

	// ==========================================================
	// register map, apb byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] ZPTR_ADDR = 8'h04;
	localparam logic [7:0] DATA_ADDR = 8'h08;
	localparam logic [7:0] CFG_ADDR = 8'h0C;
	localparam logic [7:0] STAT_ADDR = 8'h10;

	// control register bit positions
	localparam int unsigned SPE_BIT = 0;
	localparam int unsigned ERS_BIT = 1;
	localparam int unsigned WRT_BIT = 2;
	localparam int unsigned LCK_BIT = 3;
	localparam int unsigned RRE_BIT = 4;
	localparam int unsigned BSY_BIT = 6;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// low five bit command codes
	localparam logic [4:0] CMD_FILL = 5'h01;
	localparam logic [4:0] CMD_ERASE = 5'h03;
	localparam logic [4:0] CMD_WRITE = 5'h05;
	localparam logic [4:0] CMD_LOCK = 5'h09;
	localparam logic [4:0] CMD_RRE = 5'h11;

	// ==========================================================
	// flash geometry
	localparam int unsigned PC_W = 14;
	localparam int unsigned WORD_W = 6;
	localparam int unsigned PAGE_W = 8;
	localparam logic [13:0] NO_READ_WHILE_WRITE_AREA_START = 14'h3800;

	// sequencer states, gray coded along idle-armed-busy-done
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARMED = 2'b01,
		ST_BUSY = 2'b11,
		ST_DONE = 2'b10
	} seq_state_t;

	// boot start from the two fuse bits
	function automatic logic [13:0] boot_start(input logic [1:0] fuse);
		case (fuse)
			2'b11: boot_start = 14'h3F00;
			2'b10: boot_start = 14'h3E00;
			2'b01: boot_start = 14'h3C00;
			default: boot_start = 14'h3800;
		endcase
	endfunction

	// true when a word address lies in the read-while-write area
	function automatic logic in_rww(input logic [13:0] addr);
		in_rww = (addr < NO_READ_WHILE_WRITE_AREA_START);
	endfunction

endpackage

//--- rtl/flash_self_program_control.sv
// flash self-program controller: control register, z pointer decode,
// page buffer fill, timed erase/write, section busy and core halt
// assumes a core that issues store-program as a one-cycle strobe
module flash_self_program_control
	import flash_prog_pkg::*;
#(
	parameter int unsigned RC_DIV = 100,
	parameter int unsigned PROG_COUNT = PROG_TICKS
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// core side
	input wire logic STORE_STROBE,
	input wire logic [13:0] FETCH_ADDR,
	input wire logic RC_EDGE,
	// flash array side
	output logic FLASH_ERASE,
	output logic FLASH_WRITE,
	output logic LOCK_WRITE,
	output logic [7:0] FLASH_PAGE,
	output logic [7:0] LOCK_DATA,
	output logic [15:0] BUF_DATA,
	output logic [5:0] BUF_WORD,
	output logic BUF_WE,
	output logic FETCH_BLOCKED,
	output logic CORE_HALT
);
	typedef struct packed {
		seq_state_t st;
		logic [4:0] cmd;
		logic [2:0] arm;
		logic busy;
		logic [15:0] zptr;
		logic [15:0] data;
		logic [1:0] fuse;
		logic [15:0] prog;
		logic erase, write, lock, halt, blocked, we;
		logic [7:0] page;
		logic [5:0] word;
		logic [31:0] rdata;
		logic ready;
		logic deny;
	} ctl_t;
	ctl_t r, next_r;
	logic tick;

	// ==========================================================
	// rc timebase
	rc_timebase #(.DIV(RC_DIV)) u_tb (
		.clk(CLK_SYS),
		.rst(RST),
		.rc_edge(RC_EDGE),
		.tick(tick)
	);

	// ==========================================================
	// sequencer and registers
	always_comb begin
		logic wr_acc;
		logic rd_acc;
		logic [13:0] paddr14;
		wr_acc = PSEL && PENABLE && PWRITE && !r.ready;
		rd_acc = PSEL && PENABLE && !PWRITE && !r.ready;
		next_r = r;
		paddr14 = {r.zptr[14:7], 6'h00};
		next_r.ready = PSEL && PENABLE && !r.ready;
		next_r.erase = 1'b0;
		next_r.write = 1'b0;
		next_r.lock = 1'b0;
		next_r.we = 1'b0;
		// register writes; a new command only while idle
		if (wr_acc) begin
			case (PADDR)
				CTRL_ADDR: begin
					if (r.st == ST_IDLE && PWDATA[SPE_BIT]) begin
						case (PWDATA[4:0])
							CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_RRE: begin
								next_r.cmd = PWDATA[4:0];
								next_r.arm = 3'(ARM_CYCLES);
								next_r.st = ST_ARMED;
							end
							default: next_r.cmd = r.cmd;
						endcase
					end
				end
				ZPTR_ADDR: next_r.zptr = {1'b0, PWDATA[14:0]};
				DATA_ADDR: next_r.data = PWDATA[15:0];
				CFG_ADDR: next_r.fuse = PWDATA[1:0];
				default: next_r.zptr = r.zptr;
			endcase
		end
		case (r.st)
			// keep a code written this cycle, or the window opens with no command
			ST_IDLE: next_r.cmd = (next_r.st == ST_ARMED) ? next_r.cmd : 5'h00;
			ST_ARMED: begin
				if (STORE_STROBE) begin
					// page latched for every command, only erase and write use it
					next_r.page = r.zptr[14:7];
					case (r.cmd)
						CMD_FILL: begin
							next_r.word = r.zptr[6:1];
							next_r.we = 1'b1;
							// a buffer load frees the area again
							next_r.busy = 1'b0;
							next_r.blocked = 1'b0;
							next_r.st = ST_IDLE;
						end
						CMD_RRE: begin
							// re-enable only reaches here once idle, never mid-operation
							next_r.busy = 1'b0;
							next_r.blocked = 1'b0;
							next_r.st = ST_IDLE;
						end
						default: begin
							next_r.erase = (r.cmd == CMD_ERASE);
							next_r.write = (r.cmd == CMD_WRITE);
							next_r.lock = (r.cmd == CMD_LOCK);
							next_r.prog = 16'(PROG_COUNT);
							if (r.cmd != CMD_LOCK) begin
								if (in_rww(paddr14)) begin
									next_r.busy = 1'b1;
									next_r.blocked = 1'b1;
								end else begin
									next_r.halt = 1'b1;
								end
							end
							next_r.st = ST_BUSY;
						end
					endcase
				end else if (r.arm <= 3'd1) begin
					next_r.st = ST_IDLE; // window lapsed
				end else begin
					next_r.arm = r.arm - 3'd1;
				end
			end
			ST_BUSY: begin
				// rc timed, core clock only counts ticks
				if (tick) begin
					if (r.prog <= 16'h0001) begin
						next_r.st = ST_DONE;
					end else begin
						next_r.prog = r.prog - 16'h0001;
					end
				end
			end
			ST_DONE: begin
				// core runs again; the area stays blocked until re-enable or load
				next_r.halt = 1'b0;
				next_r.st = ST_IDLE;
			end
			default: next_r.st = ST_IDLE;
		endcase
		// read mux, control shows busy and the command while not idle, status the boot start
		if (rd_acc) begin
			case (PADDR)
				CTRL_ADDR: next_r.rdata = {24'h0000_00, 1'b0, r.busy, 1'b0,
					(r.st == ST_IDLE) ? 5'h00 : r.cmd};
				ZPTR_ADDR: next_r.rdata = {16'h0000, r.zptr};
				DATA_ADDR: next_r.rdata = {16'h0000, r.data};
				CFG_ADDR: next_r.rdata = {30'h0000_0000, r.fuse};
				STAT_ADDR: next_r.rdata = {16'h0000, 2'b00, boot_start(r.fuse)};
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
		// fetch gate is registered, so it trails the fetch address by one cycle
		next_r.deny = next_r.blocked && in_rww(FETCH_ADDR);
	end

	// limitation: with no separate power-on reset, reset also clears a running
	// operation; the array has to finish a started erase or write itself
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs, all from flip-flops except PSLVERR, tied low
	assign PRDATA = r.rdata;
	assign PREADY = r.ready;
	assign PSLVERR = 1'b0;
	assign FLASH_ERASE = r.erase;
	assign FLASH_WRITE = r.write;
	assign LOCK_WRITE = r.lock;
	assign FLASH_PAGE = r.page;
	assign LOCK_DATA = r.data[7:0];
	assign BUF_DATA = r.data;
	assign BUF_WORD = r.word;
	assign BUF_WE = r.we;
	assign FETCH_BLOCKED = r.deny;
	assign CORE_HALT = r.halt;
endmodule

//--- rtl/rc_timebase.sv
// rc timebase divider: one-cycle tick per rc microsecond
// assumes the calibrated rc oscillator is brought in as a synchronous enable
module rc_timebase
	import flash_prog_pkg::*;
#(
	parameter int unsigned DIV = 100
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// calibrated rc oscillator edge
	input wire logic rc_edge,
	// tick out
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} tb_t;
	tb_t r, next_r;

	// count rc edges, emit tick on wrap
	always_comb begin
		next_r = r;
		next_r.tick = 1'b0;
		if (rc_edge) begin
			if (r.cnt >= 16'(DIV - 1)) begin
				next_r.cnt = 16'h0000;
				next_r.tick = 1'b1;
			end else begin
				next_r.cnt = r.cnt + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick = r.tick;
endmodule
